// ===== pkg/ald_pkg.sv
// Package of types and constants for the arithmetic and logic datapath
package ald_pkg;

	// ****************************************************************
	// Timing counts in core clocks
	// ****************************************************************
	localparam int unsigned ALD_SHORT_CYCLES = 1;   // Byte operations
	localparam int unsigned ALD_WORD_CYCLES  = 2;   // Register pair operations

	// ****************************************************************
	// Widths and reset values
	// ****************************************************************
	localparam int unsigned ALD_BYTE_W = 8;         // Byte operand width
	localparam int unsigned ALD_WORD_W = 16;        // Pair operand width
	localparam logic [5:0]  ALD_FLAGS_RST = 6'h00;  // All flags clear after reset
	localparam logic [7:0]  ALD_SIGN_BIT  = 8'h07;  // Sign position in a byte
	localparam logic [7:0]  ALD_NIB_BIT   = 8'h04;  // Carry position of a nibble sum

	// ****************************************************************
	// Operation codes
	// ****************************************************************
	typedef enum logic [3:0] {
		ALD_OP_PLUS_REG              = 4'h0,
		ALD_OP_PLUS_REG_PROPAGATE    = 4'h1,
		ALD_OP_MINUS_REG             = 4'h2,
		ALD_OP_MINUS_CONST           = 4'h3,
		ALD_OP_MINUS_REG_PROPAGATE   = 4'h4,
		ALD_OP_MINUS_CONST_PROPAGATE = 4'h5,
		ALD_OP_WORD_PLUS_IMM         = 4'h6,
		ALD_OP_WORD_MINUS_IMM        = 4'h7,
		ALD_OP_MASK_REG              = 4'h8,
		ALD_OP_MASK_CONST            = 4'h9
	} ald_op_t;

	// ****************************************************************
	// Sequencer states, one-hot
	// ****************************************************************
	typedef enum logic [1:0] {
		ALD_ST_IDLE    = 2'h1,      // Ready for an operation
		ALD_ST_WORD_HI = 2'h2       // Second clock of a pair operation
	} ald_state_t;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	// Request from the decoder, with operands read from the register file
	typedef struct packed {
		logic        valid;     // Operation offered
		ald_op_t     op;        // Operation code
		logic [7:0]  dst;       // Destination register value
		logic [7:0]  src;       // Source register value
		logic [7:0]  imm;       // Constant
		logic [15:0] pair;      // High:low register pair value
	} ald_req_t;

	// Status flags
	typedef struct packed {
		logic h;                // nibble_propagate
		logic s;                // polarity_bit
		logic v;                // twos_wrap_flag
		logic n;                // msb_flag
		logic z;                // result_null_flag
		logic c;                // propagate_bit
	} ald_flags_t;

	// Answer to the register file
	typedef struct packed {
		logic        done;      // One-clock write-back strobe
		logic        wide;      // Write both bytes of the pair
		logic [15:0] res;       // Result, byte results in the low byte
	} ald_ans_t;

endpackage

// ===== hw/ald_datapath.sv
// Arithmetic and logic datapath for byte and register pair operations
`timescale 1ns/100ps
//
// Overview of operation
// - Register add, optional carry in, one clock
// - Register subtract, optional borrow in, one clock
// - Constant subtract, one clock, five flags
// - Constant subtract with borrow, one clock
// - Pair plus constant, two clocks, Z C N V S
// - Pair minus constant, two clocks, Z C N V S
// - AND with register or constant, Z N V
module ald_datapath
	import ald_pkg::*;
(
	input  wire logic       clk,        // Core clock
	input  wire logic       rst,        // Synchronous reset, active high
	input  wire ald_req_t   req,        // Operation request
	output ald_ans_t        ans_r,      // Write-back answer
	output ald_flags_t      flags_r,    // Status flags
	output logic            ready_r     // Request may be taken
);

	// ****************************************************************
	// State
	// ****************************************************************
	ald_state_t  state_r, state_nxt;    // Sequencer
	ald_ans_t    ans_nxt;               // Next answer
	ald_flags_t  flags_nxt;             // Next flags
	logic        ready_nxt;             // Next ready
	logic [7:0]  lo_r, lo_nxt;          // Low result byte of a pair op
	logic [7:0]  hi_r, hi_nxt;          // High operand byte of a pair op
	logic        cy_r, cy_nxt;          // Carry or borrow out of the low byte
	logic        sub_r, sub_nxt;        // Pair op subtracts
	logic        take;                  // Request taken this clock

	assign take = req.valid && ready_r;

	// ****************************************************************
	// Next-state computation
	// ****************************************************************
	always_comb begin
		logic [7:0] b;
		logic [8:0] cin9;
		logic [4:0] cin5;
		logic [8:0] r9;
		logic [4:0] r5;
		logic [7:0] r8;
		logic [15:0] w;
		b         = 8'h00;
		cin9      = 9'h000;
		cin5      = 5'h00;
		r9        = 9'h000;
		r5        = 5'h00;
		r8        = 8'h00;
		w         = 16'h0000;
		state_nxt = state_r;
		ans_nxt   = ans_r;
		flags_nxt = flags_r;            // Unlisted flags keep their value
		ready_nxt = ready_r;
		lo_nxt    = lo_r;
		hi_nxt    = hi_r;
		cy_nxt    = cy_r;
		sub_nxt   = sub_r;
		ans_nxt.done = 1'b0;
		case (state_r)
			ALD_ST_IDLE: begin
				if (take) begin
					// Second operand is the constant for const forms
					if (req.op == ALD_OP_MINUS_CONST || req.op == ALD_OP_MINUS_CONST_PROPAGATE ||
					    req.op == ALD_OP_MASK_CONST) begin
						b = req.imm;
					end else begin
						b = req.src;
					end
					// Incoming carry only for the propagate forms
					if (req.op == ALD_OP_PLUS_REG_PROPAGATE || req.op == ALD_OP_MINUS_REG_PROPAGATE ||
					    req.op == ALD_OP_MINUS_CONST_PROPAGATE) begin
						cin9 = {8'h00, flags_r.c};
						cin5 = {4'h0, flags_r.c};
					end
					case (req.op)
						// Byte additions
						ALD_OP_PLUS_REG, ALD_OP_PLUS_REG_PROPAGATE: begin
							r9 = {1'b0, req.dst} + {1'b0, b} + cin9;
							r5 = {1'b0, req.dst[3:0]} + {1'b0, b[3:0]} + cin5;
							r8 = r9[7:0];
							flags_nxt.c = r9[8];
							flags_nxt.h = r5[ALD_NIB_BIT[2:0]];
							flags_nxt.v = (req.dst[7] & b[7] & ~r8[7]) |
							              (~req.dst[7] & ~b[7] & r8[7]);
							flags_nxt.n = r8[ALD_SIGN_BIT[2:0]];
							flags_nxt.z = (r8 == 8'h00);
							ans_nxt.done = 1'b1;
							ans_nxt.wide = 1'b0;
							ans_nxt.res  = {8'h00, r8};
						end
						// Byte subtractions, register or constant
						ALD_OP_MINUS_REG, ALD_OP_MINUS_CONST, ALD_OP_MINUS_REG_PROPAGATE,
						ALD_OP_MINUS_CONST_PROPAGATE: begin
							r9 = {1'b0, req.dst} - {1'b0, b} - cin9;
							r5 = {1'b0, req.dst[3:0]} - {1'b0, b[3:0]} - cin5;
							r8 = r9[7:0];
							flags_nxt.c = r9[8];                       // Borrow out
							flags_nxt.h = r5[ALD_NIB_BIT[2:0]];        // Borrow from bit 3
							flags_nxt.v = (req.dst[7] & ~b[7] & ~r8[7]) |
							              (~req.dst[7] & b[7] & r8[7]);
							flags_nxt.n = r8[ALD_SIGN_BIT[2:0]];
							flags_nxt.z = (r8 == 8'h00);
							ans_nxt.done = 1'b1;
							ans_nxt.wide = 1'b0;
							ans_nxt.res  = {8'h00, r8};
						end
						// Bitwise AND; carry, nibble and polarity untouched
						ALD_OP_MASK_REG, ALD_OP_MASK_CONST: begin
							r8 = req.dst & b;
							flags_nxt.v = 1'b0;
							flags_nxt.n = r8[ALD_SIGN_BIT[2:0]];
							flags_nxt.z = (r8 == 8'h00);
							ans_nxt.done = 1'b1;
							ans_nxt.wide = 1'b0;
							ans_nxt.res  = {8'h00, r8};
						end
						// Pair operations: low byte now, high byte next clock
						ALD_OP_WORD_PLUS_IMM, ALD_OP_WORD_MINUS_IMM: begin
							sub_nxt = (req.op == ALD_OP_WORD_MINUS_IMM);
							if (sub_nxt) begin
								r9 = {1'b0, req.pair[7:0]} - {1'b0, req.imm};
							end else begin
								r9 = {1'b0, req.pair[7:0]} + {1'b0, req.imm};
							end
							lo_nxt    = r9[7:0];
							cy_nxt    = r9[8];
							hi_nxt    = req.pair[15:8];
							ready_nxt = 1'b0;
							state_nxt = ALD_ST_WORD_HI;
						end
						// Unknown codes are ignored
						default: begin
							ans_nxt.done = 1'b0;
						end
					endcase
				end
			end
			ALD_ST_WORD_HI: begin
				// Finish the high byte and settle the pair flags
				if (sub_r) begin
					r9 = {1'b0, hi_r} - {8'h00, cy_r};
				end else begin
					r9 = {1'b0, hi_r} + {8'h00, cy_r};
				end
				w = {r9[7:0], lo_r};
				flags_nxt.c = r9[8];
				if (sub_r) begin
					flags_nxt.v = hi_r[7] & ~w[15];
				end else begin
					flags_nxt.v = ~hi_r[7] & w[15];
				end
				flags_nxt.n = w[15];
				flags_nxt.z = (w == 16'h0000);
				flags_nxt.s = w[15] ^ flags_nxt.v;
				ans_nxt.done = 1'b1;
				ans_nxt.wide = 1'b1;
				ans_nxt.res  = w;
				ready_nxt = 1'b1;
				state_nxt = ALD_ST_IDLE;
			end
			default: begin
				state_nxt = ALD_ST_IDLE;
				ready_nxt = 1'b1;
			end
		endcase
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ALD_ST_IDLE;
			ans_r   <= '0;
			flags_r <= ALD_FLAGS_RST;
			ready_r <= 1'b1;
			lo_r    <= 8'h00;
			hi_r    <= 8'h00;
			cy_r    <= 1'b0;
			sub_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ans_r   <= ans_nxt;
			flags_r <= flags_nxt;
			ready_r <= ready_nxt;
			lo_r    <= lo_nxt;
			hi_r    <= hi_nxt;
			cy_r    <= cy_nxt;
			sub_r   <= sub_nxt;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_add_sum: assert property (take && req.op == ALD_OP_PLUS_REG |=> ans_r.done &&
		ans_r.res[7:0] == 8'($past(req.dst) + $past(req.src)))
		else $error("register add result wrong");
	a_addc_sum: assert property (take && req.op == ALD_OP_PLUS_REG_PROPAGATE |=>
		ans_r.res[7:0] == 8'($past(req.dst) + $past(req.src) + 8'($past(flags_r.c))))
		else $error("add with carry result wrong");
	a_sub_borrow: assert property (take && req.op == ALD_OP_MINUS_REG |=>
		flags_r.c == ($past(req.src) > $past(req.dst)))
		else $error("subtract borrow wrong");
	a_const_sub_zero: assert property (take && req.op == ALD_OP_MINUS_CONST |=>
		flags_r.z == ($past(req.dst) == $past(req.imm)))
		else $error("constant subtract zero flag wrong");
	a_subci_res: assert property (take && req.op == ALD_OP_MINUS_CONST_PROPAGATE |=>
		ans_r.res[7:0] == 8'($past(req.dst) - $past(req.imm) - 8'($past(flags_r.c))))
		else $error("constant subtract with borrow wrong");
	a_word_add_two: assert property (take && req.op == ALD_OP_WORD_PLUS_IMM |=>
		!ans_r.done && !ready_r ##1 ans_r.done && ans_r.wide &&
		ans_r.res == 16'($past(req.pair, 2) + {8'h00, $past(req.imm, 2)}))
		else $error("pair add wrong");
	a_word_sub_two: assert property (take && req.op == ALD_OP_WORD_MINUS_IMM |=>
		!ans_r.done ##1 ans_r.done && ans_r.wide &&
		ans_r.res == 16'($past(req.pair, 2) - {8'h00, $past(req.imm, 2)}) &&
		flags_r.c == ($past(req.imm, 2) > $past(req.pair, 2)))
		else $error("pair subtract wrong");
	a_mask_keeps: assert property (take && (req.op == ALD_OP_MASK_REG ||
		req.op == ALD_OP_MASK_CONST) |=> !flags_r.v && flags_r.c == $past(flags_r.c) &&
		flags_r.h == $past(flags_r.h) && flags_r.s == $past(flags_r.s))
		else $error("AND touched a flag it must keep");
	a_word_keeps_h: assert property (state_r == ALD_ST_WORD_HI |=>
		flags_r.h == $past(flags_r.h) && ready_r)
		else $error("pair op changed nibble flag or stayed busy");

	c_add: cover property (take && req.op == ALD_OP_PLUS_REG_PROPAGATE && flags_r.c);
	c_minus_prop: cover property (take && req.op == ALD_OP_MINUS_REG_PROPAGATE ##1 ans_r.done);
	c_word: cover property (take && req.op == ALD_OP_WORD_MINUS_IMM ##2 flags_r.z);
	c_busy: cover property (!ready_r && req.valid);

endmodule

// ===== testbench/ald_regfile_model.sv
// Decoder and register file model that offers operations and collects write-backs
`timescale 1ns/100ps
module ald_regfile_model
	import ald_pkg::*;
(
	input  wire logic       clk,      // Core clock
	input  wire ald_ans_t   ans_r,    // Write-back from the datapath
	input  wire logic       ready_r,  // Datapath may take a request
	output ald_req_t        req       // Request to the datapath
);
	// ****************************************************************
	// Request driver
	// ****************************************************************
	// Nothing offered at start
	initial req = '0;

	// Offer after gap idle cycles, hold until taken, then wait for the write-back
	task automatic issue(input ald_op_t op, input logic [7:0] d, s, i,
		input logic [15:0] p, input int gap, output int lat, output logic mid_rdy,
		output ald_ans_t a);
		int k;
		if (gap > 0) begin
			req.valid = 1'b0;
			repeat (gap) @(negedge clk);
		end
		req = '{1'b1, op, d, s, i, p};
		// Ready is looked at on the falling edge, where it has settled
		k = 0;
		while (ready_r !== 1'b1 && k < 8) begin
			@(negedge clk);
			k++;
		end
		lat = 0;
		a = '0;
		for (int n = 1; n <= 4; n++) begin
			@(negedge clk);
			// Ready one cycle after the take tells a pair op from a byte op
			if (n == 1)
				mid_rdy = ready_r;
			if (ans_r.done === 1'b1) begin
				lat = n;
				a = ans_r;
				break;
			end
		end
	endtask

	// Withdraw the request so it is not taken again
	task automatic idle;
		req.valid = 1'b0;
	endtask

	// Offer a pair request and return at once, for tests that cut it short
	task automatic offer(input ald_op_t op, input logic [15:0] p, input logic [7:0] i);
		req = '{1'b1, op, 8'h00, 8'h00, i, p};
	endtask
endmodule

// ===== testbench/arith_logic_datapath_subset_tb_top.sv
// Self-checking bench for the arithmetic and logic datapath
`timescale 1ns/100ps
module arith_logic_datapath_subset_tb_top
	import ald_pkg::*;
;
	// ****************************************************************
	// Signals
	// ****************************************************************
	// One table row: operands beside the result and flags they must give
	typedef struct packed {
		ald_op_t     op;        // Operation
		logic [7:0]  d;         // Destination operand
		logic [7:0]  s;         // Source operand
		logic [7:0]  i;         // Constant
		logic [15:0] p;         // Register pair
		logic [15:0] res;       // Expected result
		ald_flags_t  f;         // Expected flags after the row
	} ald_row_t;
	logic       clk;        // Core clock
	logic       rst;        // Synchronous reset
	ald_req_t   req;        // Request from the model
	ald_ans_t   ans_r;      // Write-back answer
	ald_flags_t flags_r;    // Status flags
	logic       ready_r;    // Datapath ready
	int         n_errors;   // Mismatch count
	int         num_checks; // Comparison count
	ald_flags_t exp_f;      // Expected flags
	ald_row_t   rows [12] = '{
		'{ALD_OP_PLUS_REG, 8'hff, 8'h01, 8'h00, 16'h0000, 16'h0000, 6'h23},
		'{ALD_OP_PLUS_REG_PROPAGATE, 8'h7f, 8'h00, 8'h00, 16'h0000, 16'h0080, 6'h2c},
		'{ALD_OP_MINUS_REG, 8'h00, 8'h01, 8'h00, 16'h0000, 16'h00ff, 6'h25},
		'{ALD_OP_MINUS_CONST_PROPAGATE, 8'h00, 8'h00, 8'hff, 16'h0000, 16'h0000, 6'h23},
		'{ALD_OP_MINUS_REG_PROPAGATE, 8'h10, 8'h0f, 8'h00, 16'h0000, 16'h0000, 6'h22},
		'{ALD_OP_MINUS_CONST, 8'h80, 8'h00, 8'h01, 16'h0000, 16'h007f, 6'h28},
		'{ALD_OP_WORD_PLUS_IMM, 8'h00, 8'h00, 8'h01, 16'hffff, 16'h0000, 6'h23},
		'{ALD_OP_WORD_MINUS_IMM, 8'h00, 8'h00, 8'h3f, 16'h0000, 16'hffc1, 6'h35},
		'{ALD_OP_WORD_PLUS_IMM, 8'h00, 8'h00, 8'h01, 16'h7fff, 16'h8000, 6'h2c},
		'{ALD_OP_WORD_MINUS_IMM, 8'h00, 8'h00, 8'h01, 16'h8000, 16'h7fff, 6'h38},
		'{ALD_OP_MASK_REG, 8'hf0, 8'h0f, 8'h00, 16'h0000, 16'h0000, 6'h32},
		'{ALD_OP_MASK_CONST, 8'h80, 8'h00, 8'hff, 16'h0000, 16'h0080, 6'h34}};

	// ****************************************************************
	// Design and far side
	// ****************************************************************
	ald_datapath dut (.clk(clk), .rst(rst), .req(req), .ans_r(ans_r), .flags_r(flags_r),
		.ready_r(ready_r));
	ald_regfile_model u_model (.clk(clk), .ans_r(ans_r), .ready_r(ready_r), .req(req));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Counts and verdict
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		#20000;
		n_errors++;
		final_report();
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		int          lat;
		logic        mr;
		logic        w;
		ald_ans_t    a;
		rst = 1'b1;
		n_errors = 0;
		num_checks = 0;
		exp_f = ALD_FLAGS_RST;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check("reset flags", flags_r, ALD_FLAGS_RST);
		check("reset ready", ready_r, 1'b1);
		check("reset done", ans_r.done, 1'b0);
		$display("test reset finished");
		// Table of operations, carry chained row to row, one slow offer
		foreach (rows[k]) begin
			w = (rows[k].op == ALD_OP_WORD_PLUS_IMM) || (rows[k].op == ALD_OP_WORD_MINUS_IMM);
			u_model.issue(rows[k].op, rows[k].d, rows[k].s, rows[k].i, rows[k].p,
				(k == 6) ? 2 : 0, lat, mr, a);
			exp_f = rows[k].f;
			check("latency", lat, w ? ALD_WORD_CYCLES : ALD_SHORT_CYCLES);
			check("ready after take", mr, !w);
			check("result", a.res, rows[k].res);
			check("wide", a.wide, w);
			check("flags", flags_r, exp_f);
		end
		$display("test table finished");
		u_model.idle();
		@(negedge clk);
		check("done one cycle", ans_r.done, 1'b0);
		check("flags held", flags_r, exp_f);
		// Unknown code: no write-back, flags unchanged
		u_model.issue(ald_op_t'(4'hf), 8'hff, 8'hff, 8'hff, 16'hffff, 0, lat, mr, a);
		u_model.idle();
		check("no done", lat, 0);
		check("flags kept", flags_r, exp_f);
		$display("test unknown code finished");
		// Reset in the middle of a pair operation: no write-back may follow
		@(negedge clk);
		u_model.offer(ALD_OP_WORD_MINUS_IMM, 16'h0000, 8'h01);
		@(negedge clk);
		check("busy before reset", ready_r, 1'b0);
		u_model.idle();
		rst = 1'b1;
		@(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check("rerun flags", flags_r, ALD_FLAGS_RST);
		check("rerun ready", ready_r, 1'b1);
		check("rerun done", ans_r.done, 1'b0);
		// First operation after reset takes the cleared carry
		u_model.issue(ALD_OP_PLUS_REG_PROPAGATE, 8'h0f, 8'h01, 8'h00, 16'h0000, 0, lat, mr, a);
		u_model.idle();
		check("rerun latency", lat, ALD_SHORT_CYCLES);
		check("rerun result", a.res, 16'h0010);
		check("rerun op flags", flags_r, 6'h20);
		$display("test second reset finished");
		final_report();
	end
endmodule
